// ### verilog/msc_core.sv
// Scaling datapath and operating control register
// What this block does
// - Scaled voltage is measured voltage over full scale times voltage factor.
// - Scaled current is measured current over full scale times current factor.
// - Current-scale x256 bit shifts the current factor left by eight.
// - Current-scale x256 lives at control bit 18, reset zero.
// - Scaled power is power over full scale times power factor, optional x256.
// - Power-scale x256 lives at control bit 11, reset one.
// - Scale factors are 24 bits; host uses shift options for larger.
// - Power factor result is measured value times its resolution.
// - Temperature result is degrees times temperature resolution.
// - Frequency result is hertz times frequency resolution.
// - Current factor scales every current result; the current average threshold is compared unscaled.
// - Voltage factor scales every voltage result; the voltage average threshold is compared unscaled.
// - Power factor scales every power result.
// - Clamp bit 17 replaces negative active power with zero.
// - Bit 15 inverts current input polarity.
// - Bit 14 inverts voltage input polarity.
// - Bit 13 auto-enables current high-pass filter below average threshold.
// - Bit 12 auto-enables voltage high-pass filter below average threshold.
// - Bit 10 freezes the die temperature result against new measurements; a register write still loads it.
// - Bit 9 forces auto-report on only if set just after reset, but reset loads bit 9 as zero, so it never does.
// - Bit 4 enables temperature gain compensation.
// - Bit 3 enables UART auto-reporting, default off.
// - Bit 1 is the manual current high-pass filter enable.
// - Bit 0 is the manual voltage high-pass filter enable.
`timescale 1ns/100ps
module msc_core
   import msc_pkg::*;
#(
   parameter int DW = MSC_DW
)
(
   input  wire logic                 core_clk,
   input  wire logic                 arst_n,
   input  wire logic                 reg_wr,
   input  wire logic                 reg_rd,
   input  wire logic        [11:0]   reg_addr,
   input  wire logic        [DW-1:0] reg_wdata,
   output logic             [DW-1:0] reg_rdata,
   input  wire logic                 adc_volt_pos_neg_valid,
   input  wire logic signed [DW-1:0] adc_volt,
   input  wire logic signed [DW-1:0] adc_curr,
   input  wire logic                 meas_valid,
   input  wire msc_qty_e             meas_qty,
   input  wire logic signed [DW-1:0] meas_value,
   input  wire logic signed [DW-1:0] volt_average,
   input  wire logic signed [DW-1:0] curr_average,
   output logic signed      [DW-1:0] volt_signed,
   output logic signed      [DW-1:0] curr_signed,
   output logic                      result_valid,
   output msc_qty_e                  result_qty,
   output logic signed      [DW-1:0] result_value,
   output logic signed      [DW-1:0] die_temperature_result,
   output logic                      volt_hpf_en,
   output logic                      curr_hpf_en,
   output logic                      gain_temp_comp,
   output logic                      auto_report_enable
);
   logic [DW-1:0] operating_control_r;
   logic [DW-1:0] current_scale_factor_r;
   logic [DW-1:0] voltage_scale_factor_r;
   logic [DW-1:0] power_scale_factor_r;
   logic [DW-1:0] power_factor_resolution_r;
   logic [DW-1:0] frequency_resolution_r;
   logic [DW-1:0] temperature_resolution_r;
   logic [DW-1:0] volt_avg_thresh_r;
   logic [DW-1:0] curr_avg_thresh_r;
   logic          boot_r;
   msc_state_e    state_r;
   msc_state_e    state_nxt;
   msc_qty_e      qty_r;
   logic signed [DW-1:0] meas_r;

   function automatic logic [DW-1:0] abs_f(input logic signed [DW-1:0] v);
      abs_f = v[DW-1] ? DW'(-v) : v;
   endfunction

   function automatic logic [DW+7:0] shift_f(input logic [DW-1:0] f, input logic sh);
      shift_f = sh ? {f, 8'h00} : {8'h00, f};
   endfunction

   // Register writes; unmapped words are ignored
   wire logic wr_ctl = reg_wr && (reg_addr == ADDR_CONTROL);
   wire logic wr_tmp = reg_wr && (reg_addr == ADDR_TEMP);
   // Register port keeps 24 bits, so wider factors are unrepresentable
   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         current_scale_factor_r    <= CUR_FACTOR_RESET;
         voltage_scale_factor_r    <= VOLT_FACTOR_RESET;
         power_scale_factor_r      <= PWR_FACTOR_RESET;
         power_factor_resolution_r <= PF_RES_RESET;
         frequency_resolution_r    <= FREQ_RES_RESET;
         temperature_resolution_r  <= TEMP_RES_RESET;
         volt_avg_thresh_r         <= ACDCV_RESET;
         curr_avg_thresh_r         <= ACDCI_RESET;
      end
      else if (reg_wr)
      begin
         case (reg_addr)
            ADDR_CUR_FACTOR:  current_scale_factor_r    <= reg_wdata;
            ADDR_VOLT_FACTOR: voltage_scale_factor_r    <= reg_wdata;
            ADDR_PWR_FACTOR:  power_scale_factor_r      <= reg_wdata;
            ADDR_PF_RES:      power_factor_resolution_r <= reg_wdata;
            ADDR_FREQ_RES:    frequency_resolution_r    <= reg_wdata;
            ADDR_TEMP_RES:    temperature_resolution_r  <= reg_wdata;
            ADDR_ACDCV:   volt_avg_thresh_r         <= reg_wdata;
            ADDR_ACDCI:   curr_avg_thresh_r         <= reg_wdata;
            default:      ;
         endcase
      end
   end

   // Reserved bits are masked off so they always read zero
   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         operating_control_r <= CTL_RESET;
         boot_r              <= 1'b1;
      end
      else
      begin
         boot_r <= 1'b0;
         if (wr_ctl)
            operating_control_r <= reg_wdata & CTL_WMASK;
         else if (boot_r && operating_control_r[CTL_ARRST])
            operating_control_r[CTL_AREN] <= 1'b1;
      end
   end

   // Read mux, registered; unmapped reads return zero
   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
         reg_rdata <= '0;
      else if (reg_rd)
      begin
         case (reg_addr)
            ADDR_CUR_FACTOR:  reg_rdata <= current_scale_factor_r;
            ADDR_VOLT_FACTOR: reg_rdata <= voltage_scale_factor_r;
            ADDR_PWR_FACTOR:  reg_rdata <= power_scale_factor_r;
            ADDR_PF_RES:      reg_rdata <= power_factor_resolution_r;
            ADDR_FREQ_RES:    reg_rdata <= frequency_resolution_r;
            ADDR_TEMP_RES:    reg_rdata <= temperature_resolution_r;
            ADDR_ACDCV:   reg_rdata <= volt_avg_thresh_r;
            ADDR_ACDCI:   reg_rdata <= curr_avg_thresh_r;
            ADDR_CONTROL: reg_rdata <= operating_control_r;
            ADDR_TEMP:    reg_rdata <= die_temperature_result;
            default:      reg_rdata <= '0;
         endcase
      end
   end

   // Control decode
   wire logic ishift_w = operating_control_r[CTL_ISHIFT];
   wire logic pshift_w = operating_control_r[CTL_PSHIFT];
   wire logic clamp_w  = operating_control_r[CTL_CLAMP];
   wire logic swapi_w  = operating_control_r[CTL_SWAPI];
   wire logic swapv_w  = operating_control_r[CTL_SWAPV];
   wire logic thold_w  = operating_control_r[CTL_THOLD];
   wire logic autoi_w  = operating_control_r[CTL_AUTOI];
   wire logic autov_w  = operating_control_r[CTL_AUTOV];

   assign gain_temp_comp     = operating_control_r[CTL_TCOMP];
   assign auto_report_enable = operating_control_r[CTL_AREN];

   // Filter enables: auto mode overrides the manual bits
   wire logic curr_small_w = abs_f(curr_average) < curr_avg_thresh_r;
   wire logic volt_small_w = abs_f(volt_average) < volt_avg_thresh_r;
   assign curr_hpf_en = autoi_w ? curr_small_w : operating_control_r[CTL_HPFI];
   assign volt_hpf_en = autov_w ? volt_small_w : operating_control_r[CTL_HPFV];

   // Polarity swap on the raw differential samples
   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         volt_signed <= '0;
         curr_signed <= '0;
      end
      else if (adc_volt_pos_neg_valid)
      begin
         volt_signed <= swapv_w ? DW'(-adc_volt) : adc_volt;
         curr_signed <= swapi_w ? DW'(-adc_curr) : adc_curr;
      end
   end

   // Factor selection; one factor per quantity family
   logic [DW+7:0] factor_w;
   logic          full_div_w;
   always_comb
   begin
      full_div_w = 1'b0;
      case (qty_r)
         MSC_Q_VOLT:
         begin
            factor_w   = {8'h00, voltage_scale_factor_r};
            full_div_w = 1'b1;
         end
         MSC_Q_CURR:
         begin
            factor_w   = shift_f(current_scale_factor_r, ishift_w);
            full_div_w = 1'b1;
         end
         MSC_Q_POWER:
         begin
            factor_w   = shift_f(power_scale_factor_r, pshift_w);
            full_div_w = 1'b1;
         end
         MSC_Q_PF:   factor_w = {8'h00, power_factor_resolution_r};
         MSC_Q_TEMP: factor_w = {8'h00, temperature_resolution_r};
         MSC_Q_FREQ: factor_w = {8'h00, frequency_resolution_r};
         default:    factor_w = '0;
      endcase
   end

   // Sequencer: capture, multiply, publish
   always_comb
   begin
      case (state_r)
         MSC_IDLE: state_nxt = meas_valid ? MSC_MULT : MSC_IDLE;
         MSC_MULT: state_nxt = MSC_DONE;
         MSC_DONE: state_nxt = MSC_IDLE;
         default:  state_nxt = MSC_IDLE;
      endcase
   end

   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         state_r <= MSC_IDLE;
         qty_r   <= MSC_Q_VOLT;
         meas_r  <= '0;
      end
      else
      begin
         state_r <= state_nxt;
         if (state_r == MSC_IDLE && meas_valid)
         begin
            qty_r  <= meas_qty;
            // Negative active power clamps to zero before scaling
            meas_r <= (meas_qty == MSC_Q_POWER && clamp_w && meas_value[DW-1]) ? '0 : meas_value;
         end
      end
   end

   logic signed [DW-1:0] prod_q;
   msc_mul #(.DW(DW)) u_mul
   (
      .core_clk (core_clk),
      .arst_n   (arst_n),
      .go       (state_r == MSC_MULT),
      .meas     (meas_r),
      .factor   (factor_w),
      .full_div (full_div_w),
      .result   (prod_q)
   );

   // Outputs held in registers; only one result in flight, extra valids are dropped
   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         result_valid           <= 1'b0;
         result_qty             <= MSC_Q_VOLT;
         result_value           <= '0;
         die_temperature_result <= '0;
      end
      else
      begin
         result_valid <= (state_r == MSC_DONE);
         if (state_r == MSC_DONE)
         begin
            result_qty   <= qty_r;
            result_value <= prod_q;
         end
         if (wr_tmp)
            die_temperature_result <= reg_wdata;
         else if (state_r == MSC_DONE && qty_r == MSC_Q_TEMP && !thold_w)
            die_temperature_result <= prod_q;
      end
   end

   // Checks
   sequence s_take_p;
      state_r == MSC_IDLE && meas_valid && meas_qty == MSC_Q_POWER && clamp_w && meas_value[DW-1];
   endsequence
   AST_CLAMP: assert property (@(posedge core_clk) disable iff (!arst_n)
      s_take_p ##3 1'b1 |-> result_valid && result_value == '0)
      else $error("Negative power not clamped");
   AST_LAT: assert property (@(posedge core_clk) disable iff (!arst_n)
      state_r == MSC_IDLE && meas_valid |-> ##3 result_valid)
      else $error("Result latency wrong");
   AST_HOLD: assert property (@(posedge core_clk) disable iff (!arst_n)
      thold_w && !wr_tmp |=> $stable(die_temperature_result))
      else $error("Temperature updated while held");
   AST_HPFI: assert property (@(posedge core_clk) disable iff (!arst_n)
      autoi_w |-> curr_hpf_en == (abs_f(curr_average) < curr_avg_thresh_r))
      else $error("Current filter auto control wrong");
   AST_HPFV: assert property (@(posedge core_clk) disable iff (!arst_n)
      !autov_w |-> volt_hpf_en == operating_control_r[CTL_HPFV])
      else $error("Voltage filter manual control wrong");
   AST_SWAPV: assert property (@(posedge core_clk) disable iff (!arst_n)
      adc_volt_pos_neg_valid && swapv_w |=> volt_signed == DW'(-$past(adc_volt)))
      else $error("Voltage swap wrong");
   AST_SWAPI: assert property (@(posedge core_clk) disable iff (!arst_n)
      adc_volt_pos_neg_valid && !swapi_w |=> curr_signed == $past(adc_curr))
      else $error("Current polarity wrong");
   AST_ARRST: assert property (@(posedge core_clk) disable iff (!arst_n)
      boot_r && operating_control_r[CTL_ARRST] && !wr_ctl |=> auto_report_enable)
      else $error("Auto report not forced at reset");
   AST_RSVD: assert property (@(posedge core_clk) disable iff (!arst_n)
      (operating_control_r & ~CTL_WMASK) == '0)
      else $error("Reserved control bits set");
endmodule

// ### verilog/msc_pkg.sv
// Package for the measurement scaling and control block
package msc_pkg;
   localparam int          MSC_DW          = 24;
   localparam int          MSC_SHIFT       = 8;
   localparam int          MSC_PW          = 48;
   // Control bit positions
   localparam int          CTL_ISHIFT      = 18;
   localparam int          CTL_CLAMP       = 17;
   localparam int          CTL_SWAPI       = 15;
   localparam int          CTL_SWAPV       = 14;
   localparam int          CTL_AUTOI       = 13;
   localparam int          CTL_AUTOV       = 12;
   localparam int          CTL_PSHIFT      = 11;
   localparam int          CTL_THOLD       = 10;
   localparam int          CTL_ARRST       = 9;
   localparam int          CTL_TCOMP       = 4;
   localparam int          CTL_AREN        = 3;
   localparam int          CTL_HPFI        = 1;
   localparam int          CTL_HPFV        = 0;
   localparam logic [23:0] CTL_RESET       = 24'h00_1815;
   // Writable bits: 18..17, 15..9 and 4..0; bit 16, 8..5 and 23..19 stay zero
   localparam logic [23:0] CTL_WMASK       = 24'h06_FE1F;
   // Scale register reset values
   localparam logic [23:0] CUR_FACTOR_RESET  = 24'd62000;
   localparam logic [23:0] VOLT_FACTOR_RESET = 24'd667000;
   localparam logic [23:0] PWR_FACTOR_RESET  = 24'd161539;
   localparam logic [23:0] PF_RES_RESET      = 24'd1000;
   localparam logic [23:0] FREQ_RES_RESET    = 24'd1000;
   localparam logic [23:0] TEMP_RES_RESET    = 24'd1000;
   localparam logic [23:0] ACDCV_RESET     = 24'd10000;
   localparam logic [23:0] ACDCI_RESET     = 24'd100;
   // Word addresses on the register port
   localparam logic [11:0] ADDR_CUR_FACTOR  = 12'h04F;
   localparam logic [11:0] ADDR_VOLT_FACTOR = 12'h050;
   localparam logic [11:0] ADDR_PWR_FACTOR  = 12'h051;
   localparam logic [11:0] ADDR_PF_RES      = 12'h052;
   localparam logic [11:0] ADDR_FREQ_RES    = 12'h053;
   localparam logic [11:0] ADDR_TEMP_RES    = 12'h054;
   localparam logic [11:0] ADDR_ACDCV      = 12'h064;
   localparam logic [11:0] ADDR_ACDCI      = 12'h065;
   localparam logic [11:0] ADDR_CONTROL    = 12'h0F0;
   localparam logic [11:0] ADDR_TEMP       = 12'h0F1;
   // Quantity selector for the scaler
   typedef enum logic [2:0]
   {
      MSC_Q_VOLT  = 3'd0,
      MSC_Q_CURR  = 3'd1,
      MSC_Q_POWER = 3'd2,
      MSC_Q_PF    = 3'd3,
      MSC_Q_TEMP  = 3'd4,
      MSC_Q_FREQ  = 3'd5
   } msc_qty_e;
   // Scaler sequence
   typedef enum logic [1:0]
   {
      MSC_IDLE = 2'b00,
      MSC_MULT = 2'b01,
      MSC_DONE = 2'b11
   } msc_state_e;
endpackage

// ### verilog/msc_mul.sv
// Registered signed multiplier with fixed-point normalisation
`timescale 1ns/100ps
module msc_mul
   import msc_pkg::*;
#(
   parameter int DW = 24
)
(
   input  wire logic                 core_clk,
   input  wire logic                 arst_n,
   input  wire logic                 go,
   input  wire logic signed [DW-1:0] meas,
   input  wire logic        [DW+7:0] factor,
   input  wire logic                 full_div,
   output logic signed      [DW-1:0] result
);
   // Full-scale inputs are Q1.23 fractions, so divide by 2^23; others are integers
   wire logic signed [2*DW+8:0] prod_w = meas * $signed({1'b0, factor});
   wire logic signed [2*DW+8:0] norm_w = full_div ? (prod_w >>> (DW-1)) : prod_w;

   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
         result <= '0;
      else if (go)
         result <= norm_w[DW-1:0];
   end
endmodule

// ### tb/msc_host.sv
// Host controller model for the register port
`timescale 1ns/100ps
module msc_host
   import msc_pkg::*;
(
   input  wire logic        core_clk,
   output logic             reg_wr,
   output logic             reg_rd,
   output logic      [11:0] reg_addr,
   output logic      [23:0] reg_wdata,
   input  wire logic [23:0] reg_rdata
);
   initial
   begin
      reg_wr    = 1'b0;
      reg_rd    = 1'b0;
      reg_addr  = 12'h000;
      reg_wdata = 24'h00_0000;
   end
   // One 24-bit word a write; larger factors need the shift bits
   task automatic wr(input logic [11:0] addr, input logic [23:0] data);
   begin
      @(negedge core_clk);
      reg_addr  = addr;
      reg_wdata = data;
      reg_wr    = 1'b1;
      @(negedge core_clk);
      reg_wr    = 1'b0;
      // Inverted stale data so a missed strobe cannot look right
      reg_wdata = ~data;
   end
   endtask
   task automatic wr_ctl(input logic [23:0] data);
   begin
      wr(ADDR_CONTROL, data & CTL_WMASK);
   end
   endtask
   task automatic rd(input logic [11:0] addr, output logic [23:0] data);
   begin
      @(negedge core_clk);
      reg_addr = addr;
      reg_rd   = 1'b1;
      @(negedge core_clk);
      reg_rd   = 1'b0;
      @(negedge core_clk);
      data     = reg_rdata;
   end
   endtask
endmodule

// ### tb/msc_core_tb.sv
// Self-checking testbench for the scaling datapath and control register
`timescale 1ns/100ps
module msc_core_tb
   import msc_pkg::*;
   ;
   logic               core_clk, arst_n, reg_wr, reg_rd, adc_valid, meas_valid;
   logic        [11:0] reg_addr;
   logic        [23:0] reg_wdata, reg_rdata, rv;
   logic signed [23:0] adc_volt, adc_curr, meas_value, volt_average, curr_average;
   logic signed [23:0] volt_signed, curr_signed, result_value, die_temp;
   msc_qty_e           meas_qty, result_qty;
   logic               result_valid, volt_hpf_en, curr_hpf_en, temp_comp, report_en;
   int                 num_errors, comparisons, cycles;

   msc_core dut (.core_clk(core_clk), .arst_n(arst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .adc_volt_pos_neg_valid(adc_valid), .adc_volt(adc_volt), .adc_curr(adc_curr),
      .meas_valid(meas_valid), .meas_qty(meas_qty), .meas_value(meas_value),
      .volt_average(volt_average), .curr_average(curr_average),
      .volt_signed(volt_signed), .curr_signed(curr_signed), .result_valid(result_valid),
      .result_qty(result_qty), .result_value(result_value),
      .die_temperature_result(die_temp), .volt_hpf_en(volt_hpf_en),
      .curr_hpf_en(curr_hpf_en), .gain_temp_comp(temp_comp), .auto_report_enable(report_en));
   msc_host host (.core_clk(core_clk), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

   initial
   begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   task automatic complete_run();
   begin
      if (num_errors == 0 && comparisons > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   end
   endtask
   // Generous ceiling: the whole sequence needs well under 1000 cycles
   always @(posedge core_clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         num_errors++;
         complete_run();
      end
   end
   task automatic check(input string name, input logic [23:0] exp, input logic [23:0] got);
   begin
      comparisons++;
      if (got !== exp)
      begin
         num_errors++;
         $display("BAD %s expected %h seen %h", name, exp, got);
      end
   end
   endtask
   // Q1.23 fraction of full scale times the effective factor
   function automatic logic [23:0] qmul(input logic signed [23:0] m, input logic [31:0] f);
      logic signed [63:0] p;
      p = 64'(m) * $signed(64'(f));
      return p[46:23];
   endfunction
   task automatic meas(input msc_qty_e q, input logic [23:0] v, input logic [23:0] exp);
      int n;
   begin
      @(negedge core_clk);
      meas_qty   = q;
      meas_value = v;
      meas_valid = 1'b1;
      @(negedge core_clk);
      meas_valid = 1'b0;
      n = 0;
      while (result_valid !== 1'b1 && n < 8)
      begin
         @(negedge core_clk);
         n++;
      end
      check("result_value", exp, result_value);
      check("result_qty", 24'(q), 24'(result_qty));
   end
   endtask
   task automatic t_reset_values();
   begin
      host.rd(ADDR_CONTROL, rv);
      check("control", 24'h00_1815, rv);
      check("comp_report", 24'h00_0002, {22'h0, temp_comp, report_en});
      host.rd(ADDR_VOLT_FACTOR, rv);
      check("volt_factor", 24'd667000, rv);
      host.rd(12'h0FF, rv);
      check("unmapped", 24'h00_0000, rv);
   end
   endtask
   task automatic t_control_bits();
   begin
      host.wr(ADDR_CONTROL, 24'hFF_FFFF);
      host.rd(ADDR_CONTROL, rv);
      check("control_mask", 24'h06_FE1F, rv);
      check("report_on", 24'h00_0001, {23'h0, report_en});
      host.wr(12'h0FE, 24'h12_3456);
      host.wr_ctl(24'h00_0000);
      check("comp_off", 24'h00_0000, {22'h0, temp_comp, report_en});
      host.wr_ctl(CTL_RESET);
   end
   endtask
   task automatic t_scaling();
   begin
      meas(MSC_Q_VOLT, 24'h40_0000, 24'd333500);
      meas(MSC_Q_VOLT, 24'hC0_0000, 24'hFA_E944);
      host.wr(ADDR_CUR_FACTOR, 24'd1000);
      meas(MSC_Q_CURR, 24'h40_0000, 24'd500);
      host.wr_ctl(CTL_RESET | 24'h04_0000);
      meas(MSC_Q_CURR, 24'h40_0000, qmul(24'h40_0000, 32'd256000));
      host.wr(ADDR_PWR_FACTOR, 24'd1000);
      host.wr_ctl(CTL_RESET);
      meas(MSC_Q_POWER, 24'h20_0000, 24'd64000);
      meas(MSC_Q_POWER, 24'hE0_0000, 24'hFF_0600);
      host.wr_ctl(CTL_RESET | 24'h02_0000);
      meas(MSC_Q_POWER, 24'hE0_0000, 24'h00_0000);
      meas(MSC_Q_POWER, 24'h20_0000, 24'd64000);
      host.wr_ctl(CTL_RESET & ~24'h00_0800);
      meas(MSC_Q_POWER, 24'h20_0000, 24'd250);
      meas(MSC_Q_PF, 24'd1, 24'd1000);
      meas(MSC_Q_FREQ, 24'd60, 24'd60000);
      meas(MSC_Q_TEMP, 24'd27, 24'd27000);
      check("die_temp", 24'd27000, die_temp);
      host.wr_ctl(CTL_RESET | 24'h00_0400);
      meas(MSC_Q_TEMP, 24'd30, 24'd30000);
      check("die_temp_hold", 24'd27000, die_temp);
      host.wr(ADDR_TEMP, 24'd25000);
      host.rd(ADDR_TEMP, rv);
      check("die_temp_write", 24'd25000, rv);
      host.wr_ctl(CTL_RESET);
   end
   endtask
   task automatic sample(input logic [23:0] v, input logic [23:0] c);
   begin
      @(negedge core_clk);
      adc_volt  = v;
      adc_curr  = c;
      adc_valid = 1'b1;
      @(negedge core_clk);
      adc_valid = 1'b0;
   end
   endtask
   task automatic t_polarity();
   begin
      sample(24'd100, 24'hFF_FFF9);
      check("volt_signed", 24'd100, volt_signed);
      check("curr_signed", 24'hFF_FFF9, curr_signed);
      host.wr_ctl(CTL_RESET | 24'h00_C000);
      sample(24'd100, 24'hFF_FFF9);
      check("volt_swapped", 24'hFF_FF9C, volt_signed);
      check("curr_swapped", 24'd7, curr_signed);
      host.wr_ctl(CTL_RESET);
   end
   endtask
   task automatic t_filter();
   begin
      volt_average = 24'hFF_D8F1;
      curr_average = 24'd50;
      @(negedge core_clk);
      check("vhpf_auto_in", 24'h1, 24'(volt_hpf_en));
      check("ihpf_manual", 24'h0, 24'(curr_hpf_en));
      volt_average = 24'hFF_B1E0;
      @(negedge core_clk);
      check("vhpf_auto_out", 24'h0, 24'(volt_hpf_en));
      host.wr_ctl(24'h00_2812);
      check("ihpf_auto_in", 24'h1, 24'(curr_hpf_en));
      check("vhpf_manual", 24'h0, 24'(volt_hpf_en));
      curr_average = 24'd100;
      @(negedge core_clk);
      check("ihpf_auto_edge", 24'h0, 24'(curr_hpf_en));
      host.wr_ctl(24'h00_0813);
      check("hpf_manual_on", 24'h3, {22'h0, curr_hpf_en, volt_hpf_en});
   end
   endtask
   initial
   begin
      num_errors   = 0;
      comparisons  = 0;
      cycles       = 0;
      arst_n       = 1'b0;
      adc_valid    = 1'b0;
      adc_volt     = 24'h00_0000;
      adc_curr     = 24'h00_0000;
      meas_valid   = 1'b0;
      meas_qty     = MSC_Q_VOLT;
      meas_value   = 24'h00_0000;
      volt_average = 24'h00_0000;
      curr_average = 24'h00_0000;
      repeat (10) @(posedge core_clk);
      @(negedge core_clk);
      arst_n = 1'b1;
      t_reset_values();
      t_control_bits();
      t_scaling();
      t_polarity();
      t_filter();
      complete_run();
   end
endmodule
